// File: verilog/codec_ctrl_regs.sv
// pll multiplier, control word four and handset gain/agc registers behind apb
// Notes on behaviour
// - pll integer multiplier is bits 7..2, values 1..63; zero is never accepted
// - pll fraction bits 15..2 reset to zero, writes above 9999 stored as 9999
// - bits 15..11 turn off soft-stepping per gain stage; zero keeps stepping on
// - sidetone and cell-phone gains step 0.5 dB per reference sample
// - buzzer gain steps 3 dB per reference sample
// - agc hysteresis bits 10..9: 1, 2, 4 dB, or none for 11
// - hysteresis only counts while agc serves the handset input
// - headset bias bits 8..7: 3.3 V, 2.5 V, then 2.0 V for both upper codes
// - handset bias bit 6: 0 gives 2.5 V, 1 gives 2.0 V
// - read-only bit 1 shows a headphone short circuit
// - handset mute bit 15 resets to one, input starts muted
// - handset gain bits 14..8 in 0.5 dB steps, reset all ones
// - with agc on and handset selected, mute and gain bits read agc gain
// - that readback is signed 8-bit in 0.5 dB units, -12 to +59.5 dB
// - agc target bits 7..5 pick the aimed adc level, -5.5 to -24 dB
// - agc timing bits 4..1 pick attack and decay times, fixed in ms
// - bit 0 hands the adc gain to the agc; otherwise written gain rules
//
// Our own choice: the APB register port.
module codec_ctrl_regs
    import codec_regs_pkg::*;
#(
    parameter int MS_CYCLES = codec_regs_pkg::MS_CYCLES
) (
    // clock and reset
    input  wire logic                       mclk_i,
    input  wire logic                       rst_b_i,
    // apb slave
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [codec_regs_pkg::APB_AW-1:0] paddr_i,
    input  wire logic [31:0]                pwdata_i,
    output logic [31:0]                     prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o,
    output logic                            irq_o,
    // pll
    input  wire logic                       pll_enable_i,
    output logic [5:0]                      pll_integer_mult_o,
    output logic [13:0]                     pll_fraction_mult_o,
    output logic                            pll_mult_valid_o,
    // gain stages
    input  wire logic                       fs_tick_i,
    input  wire logic [6:0]                 sidetone_target_i,
    input  wire logic [6:0]                 cell_target_i,
    input  wire logic [6:0]                 buzzer_target_i,
    output logic [6:0]                      sidetone_gain_o,
    output logic [6:0]                      cell_gain_o,
    output logic [6:0]                      buzzer_gain_o,
    output logic                            dac_pga_step_off_o,
    // microphone bias and protection
    output logic [1:0]                      headset_bias_level_o,
    output logic [1:0]                      handset_bias_level_o,
    input  wire logic                       short_detect_i,
    // handset adc path
    input  wire logic                       handset_sel_i,
    input  wire logic                       adc_level_valid_i,
    input  wire logic signed [7:0]          adc_level_i,
    output logic signed [7:0]               adc_gain_o,
    output logic                            adc_mute_o
);
    import codec_regs_pkg::*;

    localparam int MS_W = $clog2(MS_CYCLES);

    if (MS_CYCLES < 2) begin : g_bad_ms
        $error("codec_ctrl_regs: MS_CYCLES must be at least 2");
    end

    logic [5:0]         j_q;
    logic [13:0]        frac_q;
    logic [9:0]         ctrl4_q;
    logic [15:0]        hs_q;
    logic [IRQ_W-1:0]   stat_q;
    logic [IRQ_W-1:0]   stat_d;
    logic [IRQ_W-1:0]   mask_q;
    logic               short_q;
    logic [31:0]        prdata_q;
    logic [MS_W-1:0]    ms_cnt_q;
    logic signed [7:0]  adc_gain_q;
    logic               adc_mute_q;

    // apb decode: zero wait states, data captured in the setup cycle
    wire setup_w   = psel_i && !penable_i;
    wire access_w  = psel_i && penable_i;
    wire wr_w      = access_w && pwrite_i;
    wire hit_jint  = paddr_i == ADDR_PLL_INT;
    wire hit_frac  = paddr_i == ADDR_PLL_FRAC;
    wire hit_ctrl4 = paddr_i == ADDR_CTRL4;
    wire hit_hs    = paddr_i == ADDR_HS_GAIN;
    wire hit_stat  = paddr_i == ADDR_IRQ_STAT;
    wire hit_mask  = paddr_i == ADDR_IRQ_MASK;
    wire mapped_w  = hit_jint || hit_frac || hit_ctrl4 || hit_hs || hit_stat || hit_mask;
    wire stat_rd_w = access_w && !pwrite_i && hit_stat;

    // field views
    wire [5:0]  j_wr_w    = pwdata_i[J_LSB +: 6];
    wire [13:0] frac_wr_w = pwdata_i[FRAC_LSB +: 14];
    wire        frac_big  = frac_wr_w > FRAC_MAX;
    wire [1:0]  hys_sel   = ctrl4_q[HYS_LSB - 6 +: 2];
    wire [1:0]  hbias_sel = ctrl4_q[HBIAS_LSB - 6 +: 2];
    wire        agc_on_w  = hs_q[AGC_BIT];
    wire        agc_hs_w  = agc_on_w && handset_sel_i;

    // events into sticky status
    wire [IRQ_W-1:0] event_w;
    assign event_w[IRQ_SHORT] = short_detect_i && !short_q;
    assign event_w[IRQ_CLAMP] = wr_w && hit_frac && frac_big;
    assign event_w[IRQ_JREJ]  = wr_w && hit_jint && j_wr_w == 6'h00;

    // agc and stepped gains
    logic signed [7:0] agc_gain_w;
    wire               ms_tick_w = ms_cnt_q == MS_W'(MS_CYCLES - 1);
    wire [6:0]         hs_step_w;

    // readback words; reserved bits answer zero
    wire [15:0] gain_rd_w = agc_hs_w ? {agc_gain_w, hs_q[7:0]} : hs_q;
    wire [15:0] ctrl4_rd_w = {ctrl4_q, 4'h0, short_q, 1'b0};
    wire [31:0] rd_mux_w =
        hit_jint  ? {24'h000000, j_q, 2'b00} :
        hit_frac  ? {16'h0000, frac_q, 2'b00} :
        hit_ctrl4 ? {16'h0000, ctrl4_rd_w} :
        hit_hs    ? {16'h0000, gain_rd_w} :
        hit_stat  ? {29'h00000000, stat_q} :
        hit_mask  ? {29'h00000000, mask_q} : 32'h00000000;

    // set wins over the read-clear of the captured bits
    assign stat_d = (stat_q & ~(stat_rd_w ? prdata_q[IRQ_W-1:0] : '0)) | event_w;

    assign prdata_o  = prdata_q;
    assign pready_o  = access_w;
    assign pslverr_o = access_w && !mapped_w;
    assign irq_o     = |(stat_q & mask_q);

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            prdata_q <= 32'h00000000;
            stat_q   <= '0;
            mask_q   <= '0;
            short_q  <= 1'b0;
            ms_cnt_q <= '0;
        end else begin
            if (setup_w) prdata_q <= rd_mux_w;
            if (wr_w && hit_mask) mask_q <= pwdata_i[IRQ_W-1:0];
            stat_q   <= stat_d;
            short_q  <= short_detect_i;
            ms_cnt_q <= ms_tick_w ? '0 : ms_cnt_q + MS_W'(1);
        end
    end

    // pll multiplier registers
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            j_q    <= J_RST;
            frac_q <= FRAC_RST;
        end else begin
            if (wr_w && hit_jint && j_wr_w != 6'h00) j_q <= j_wr_w;
            if (wr_w && hit_frac) frac_q <= frac_big ? FRAC_MAX : frac_wr_w;
        end
    end

    // control word four and handset gain word
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            ctrl4_q <= CTRL4_RST;
            hs_q    <= HS_RST;
        end else begin
            if (wr_w && hit_ctrl4) ctrl4_q <= pwdata_i[15:6];
            if (wr_w && hit_hs) hs_q <= pwdata_i[15:0];
        end
    end

    assign pll_integer_mult_o  = j_q;
    assign pll_fraction_mult_o = frac_q;
    assign pll_mult_valid_o    = pll_enable_i;

    // bias decode; both upper headset codes give the lowest level
    assign headset_bias_level_o = (hbias_sel == 2'b00) ? BIAS_3V3 :
                                  (hbias_sel == 2'b01) ? BIAS_2V5 : BIAS_2V0;
    assign handset_bias_level_o = ctrl4_q[NBIAS_BIT - 6] ? BIAS_2V0 : BIAS_2V5;
    assign dac_pga_step_off_o   = ctrl4_q[STEP_DAC_BIT - 6];

    // four stepped stages: sidetone, cell phone, buzzer, handset input
    gain_if #(.W(7)) st [4] ();
    wire [6:0] tgt_w  [4];
    wire       soff_w [4];
    assign tgt_w[0]  = sidetone_target_i;
    assign tgt_w[1]  = cell_target_i;
    assign tgt_w[2]  = buzzer_target_i;
    assign tgt_w[3]  = hs_q[GAIN_LSB +: 7];
    assign soff_w[0] = ctrl4_q[STEP_SIDE_BIT - 6];
    assign soff_w[1] = ctrl4_q[STEP_CELL_BIT - 6];
    assign soff_w[2] = ctrl4_q[STEP_BUZ_BIT - 6];
    assign soff_w[3] = ctrl4_q[STEP_IN_BIT - 6];

    for (genvar i = 0; i < 4; i++) begin : g_stage
        assign st[i].target   = tgt_w[i];
        assign st[i].step_off = soff_w[i];
        assign st[i].tick     = fs_tick_i;
        // buzzer moves in 3 dB steps, the rest in 0.5 dB
        gain_stepper #(
            .W    (7),
            .STEP ((i == 2) ? STEP_COARSE : STEP_FINE),
            .RST  ((i == 3) ? HS_RST[GAIN_LSB +: 7] : 7'h00)
        ) u_step (
            .mclk_i  (mclk_i),
            .rst_b_i (rst_b_i),
            .g       (st[i])
        );
    end

    assign sidetone_gain_o = st[0].applied;
    assign cell_gain_o     = st[1].applied;
    assign buzzer_gain_o   = st[2].applied;
    assign hs_step_w       = st[3].applied;

    // hysteresis dropped unless the agc is serving the handset
    agc_engine u_agc (
        .mclk_i        (mclk_i),
        .rst_b_i       (rst_b_i),
        .enable_i      (agc_on_w),
        .ms_tick_i     (ms_tick_w),
        .hys_i         (handset_sel_i ? hys_lut(hys_sel) : 4'h0),
        .attack_ms_i   (attack_ms_lut(hs_q[TC_LSB +: 2])),
        .decay_ms_i    (decay_ms_lut(hs_q[TC_LSB + 2 +: 2])),
        .target_i      (agc_target_lut(hs_q[TGT_LSB +: 3])),
        .level_valid_i (adc_level_valid_i),
        .level_i       (adc_level_i),
        .gain_o        (agc_gain_w)
    );

    // adc gain owner: agc when enabled, else written mute and stepped gain
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            adc_gain_q <= 8'sh00;
            adc_mute_q <= 1'b1;
        end else begin
            adc_gain_q <= agc_on_w ? agc_gain_w : $signed({1'b0, hs_step_w});
            adc_mute_q <= agc_on_w ? 1'b0 : hs_q[MUTE_BIT];
        end
    end

    assign adc_gain_o = adc_gain_q;
    assign adc_mute_o = adc_mute_q;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_hs_read;
        setup_w && !pwrite_i && hit_hs && agc_hs_w;
    endsequence
    sequence s_stat_read;
        setup_w && !pwrite_i && hit_stat ##1 stat_rd_w;
    endsequence

    a_j_nonzero: assert property (j_q != 6'h00)
        else $error("pll integer multiplier is zero");
    a_frac_clamp: assert property (wr_w && hit_frac && frac_big |=> frac_q == FRAC_MAX)
        else $error("pll fraction not clamped");
    a_short_flag: assert property (short_detect_i |=> ctrl4_rd_w[SHORT_BIT])
        else $error("short flag missing");
    a_mute_reset: assert property ($rose(rst_b_i) |-> hs_q == HS_RST && adc_mute_q)
        else $error("handset gain word not at reset value");
    a_agc_readback: assert property (s_hs_read |=> prdata_q[15:8] == $past(agc_gain_w))
        else $error("agc gain not in readback");
    a_agc_owns_gain: assert property (agc_on_w |=> adc_gain_q == $past(agc_gain_w)
        && !adc_mute_q)
        else $error("adc gain not driven by agc");
    a_bias_upper: assert property (hbias_sel[1] |-> headset_bias_level_o == BIAS_2V0)
        else $error("headset bias upper code wrong");
    a_stat_clear: assert property (s_stat_read |=>
        (stat_q & $past(prdata_q[IRQ_W-1:0]) & ~$past(event_w)) == '0)
        else $error("status read did not clear bits");
endmodule : codec_ctrl_regs

// File: inc/codec_regs_pkg.sv
// shared offsets, field layouts, reset values, tables and timing for the codec control slice
package codec_regs_pkg;
    // register indices; byte address is four times the index
    localparam int         APB_AW        = 8;
    localparam logic [7:0] IDX_PLL_INT   = 8'h1B;
    localparam logic [7:0] IDX_PLL_FRAC  = 8'h1C;
    localparam logic [7:0] IDX_CTRL4     = 8'h1D;
    localparam logic [7:0] IDX_HS_GAIN   = 8'h1E;
    localparam logic [7:0] IDX_IRQ_STAT  = 8'h20;
    localparam logic [7:0] IDX_IRQ_MASK  = 8'h21;
    localparam logic [7:0] ADDR_PLL_INT  = IDX_PLL_INT * 8'h04;
    localparam logic [7:0] ADDR_PLL_FRAC = IDX_PLL_FRAC * 8'h04;
    localparam logic [7:0] ADDR_CTRL4    = IDX_CTRL4 * 8'h04;
    localparam logic [7:0] ADDR_HS_GAIN  = IDX_HS_GAIN * 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = IDX_IRQ_STAT * 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK = IDX_IRQ_MASK * 8'h04;
    // pll fields
    localparam int          J_LSB     = 2;
    localparam logic [5:0]  J_RST     = 6'h01;
    localparam int          FRAC_LSB  = 2;
    localparam logic [13:0] FRAC_MAX  = 14'h270F;
    localparam logic [13:0] FRAC_RST  = 14'h0000;
    // control word four fields
    localparam int          STEP_IN_BIT   = 15;
    localparam int          STEP_DAC_BIT  = 14;
    localparam int          STEP_SIDE_BIT = 13;
    localparam int          STEP_CELL_BIT = 12;
    localparam int          STEP_BUZ_BIT  = 11;
    localparam int          HYS_LSB       = 9;
    localparam int          HBIAS_LSB     = 7;
    localparam int          NBIAS_BIT     = 6;
    localparam int          SHORT_BIT     = 1;
    localparam logic [9:0]  CTRL4_RST     = 10'h000;
    // handset gain word fields
    localparam int          MUTE_BIT  = 15;
    localparam int          GAIN_LSB  = 8;
    localparam int          TGT_LSB   = 5;
    localparam int          TC_LSB    = 1;
    localparam int          AGC_BIT   = 0;
    localparam logic [15:0] HS_RST    = 16'hFF00;
    // interrupt status bits
    localparam int          IRQ_W     = 3;
    localparam int          IRQ_SHORT = 0;
    localparam int          IRQ_CLAMP = 1;
    localparam int          IRQ_JREJ  = 2;
    // timing and gain steps (units of 0.5 dB)
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          MS_NS         = 1000000;
    localparam int          MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          STEP_FINE     = 1;
    localparam int          STEP_COARSE   = 6;
    localparam int          AGC_SHIFT     = 2;
    localparam logic signed [7:0] AGC_MIN = 8'shE8;
    localparam logic signed [7:0] AGC_MAX = 8'sh77;

    typedef enum logic [1:0] {AGC_HOLD = 2'b00, AGC_ATTACK = 2'b01, AGC_DECAY = 2'b10}
        agc_dir_type;
    typedef enum logic [1:0] {BIAS_3V3 = 2'b00, BIAS_2V5 = 2'b01, BIAS_2V0 = 2'b10}
        bias_level_type;

    function automatic logic signed [7:0] agc_target_lut(input logic [2:0] sel);
        logic signed [7:0] t;
        case (sel)
            3'h0:    t = 8'shF5;
            3'h1:    t = 8'shF0;
            3'h2:    t = 8'shEC;
            3'h3:    t = 8'shE8;
            3'h4:    t = 8'shE4;
            3'h5:    t = 8'shDE;
            3'h6:    t = 8'shD8;
            default: t = 8'shD0;
        endcase
        return t;
    endfunction : agc_target_lut

    function automatic logic [3:0] hys_lut(input logic [1:0] sel);
        return (sel == 2'h3) ? 4'h0 : (4'h2 << sel);
    endfunction : hys_lut

    function automatic logic [8:0] attack_ms_lut(input logic [1:0] sel);
        return (sel == 2'h0) ? 9'h008 : (sel == 2'h1) ? 9'h00B :
               (sel == 2'h2) ? 9'h010 : 9'h014;
    endfunction : attack_ms_lut

    function automatic logic [8:0] decay_ms_lut(input logic [1:0] sel);
        return (sel == 2'h0) ? 9'h064 : (sel == 2'h1) ? 9'h0C8 :
               (sel == 2'h2) ? 9'h190 : 9'h1F4;
    endfunction : decay_ms_lut
endpackage : codec_regs_pkg

// File: inc/gain_if.sv
// one gain stage: requested gain in, stepped gain out
interface gain_if #(parameter int W = 7);
    logic [W-1:0] target;
    logic [W-1:0] applied;
    logic         step_off;
    logic         tick;
    modport ctrl  (output target, output step_off, output tick, input applied);
    modport stage (input target, input step_off, input tick, output applied);
endinterface : gain_if

// File: verilog/gain_stepper.sv
// soft-stepping gain stage, moves by STEP units per reference sample tick
module gain_stepper #(
    parameter int           W    = 7,
    parameter int           STEP = 1,
    parameter logic [W-1:0] RST  = '0
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // gain stage
    gain_if.stage    g
);
    import codec_regs_pkg::*;

    logic [W-1:0] applied_q;
    logic [W-1:0] applied_d;

    wire          up_w   = g.target > applied_q;
    wire [W-1:0]  dist_w = up_w ? g.target - applied_q : applied_q - g.target;
    wire          near_w = dist_w <= W'(STEP);

    // stepping off jumps at once; otherwise one step per tick
    assign applied_d = g.step_off ? g.target :
                       !g.tick    ? applied_q :
                       near_w     ? g.target :
                       up_w       ? applied_q + W'(STEP) : applied_q - W'(STEP);
    assign g.applied = applied_q;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) applied_q <= RST;
        else applied_q <= applied_d;
    end

    if (STEP < 1 || STEP >= (1 << W)) begin : g_bad_step
        $error("gain_stepper: STEP out of range");
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    a_step_size: assert property (g.tick && !g.step_off |=>
        applied_q == $past(g.target) || applied_q == $past(applied_q) + W'(STEP) ||
        applied_q == $past(applied_q) - W'(STEP))
        else $error("gain moved by more than one step");
    a_step_off_jump: assert property (g.step_off |=> applied_q == $past(g.target))
        else $error("disabled stepping did not jump to target");
    a_step_idle: assert property (!g.tick && !g.step_off |=> $stable(applied_q))
        else $error("gain moved without a sample tick");
endmodule : gain_stepper

// File: verilog/agc_engine.sv
// handset agc: one 0.5 dB step per time-constant slice toward the target level
module agc_engine (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_b_i,
    // control
    input  wire logic        enable_i,
    input  wire logic        ms_tick_i,
    input  wire logic [3:0]  hys_i,
    input  wire logic [8:0]  attack_ms_i,
    input  wire logic [8:0]  decay_ms_i,
    input  wire logic signed [7:0] target_i,
    // measured level
    input  wire logic        level_valid_i,
    input  wire logic signed [7:0] level_i,
    // applied gain
    output logic signed [7:0] gain_o
);
    import codec_regs_pkg::*;

    agc_dir_type       dir_q;
    agc_dir_type       dir_d;
    logic [8:0]        ms_q;
    logic [8:0]        ms_d;
    logic signed [7:0] gain_q;
    logic signed [7:0] gain_d;

    wire signed [9:0] lvl_w   = 10'(level_i);
    wire signed [9:0] upper_w = 10'(target_i) + $signed({6'h00, hys_i});
    wire signed [9:0] lower_w = 10'(target_i) - $signed({6'h00, hys_i});
    wire [8:0] period_w = (dir_q == AGC_ATTACK) ? attack_ms_i : decay_ms_i;
    wire [8:0] slice_w  = ((period_w >> AGC_SHIFT) == 9'h000) ? 9'h001 : period_w >> AGC_SHIFT;
    wire       due_w    = ms_tick_i && dir_q != AGC_HOLD && (ms_q + 9'h001) >= slice_w;

    // a deadband of the hysteresis around the target holds the gain still
    assign dir_d  = !level_valid_i   ? dir_q :
                    lvl_w > upper_w  ? AGC_ATTACK :
                    lvl_w < lower_w  ? AGC_DECAY : AGC_HOLD;
    // too loud lowers gain at attack rate, too quiet raises it at decay rate
    assign gain_d = !due_w ? gain_q :
                    (dir_q == AGC_ATTACK && gain_q > AGC_MIN) ? gain_q - 8'sh01 :
                    (dir_q == AGC_DECAY && gain_q < AGC_MAX)  ? gain_q + 8'sh01 : gain_q;
    assign ms_d   = (due_w || dir_d != dir_q) ? 9'h000 : ms_tick_i ? ms_q + 9'h001 : ms_q;
    assign gain_o = gain_q;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i || !enable_i) begin
            dir_q  <= AGC_HOLD;
            ms_q   <= 9'h000;
            gain_q <= 8'sh00;
        end else begin
            dir_q  <= dir_d;
            ms_q   <= ms_d;
            gain_q <= gain_d;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    a_agc_range: assert property (gain_q >= AGC_MIN && gain_q <= AGC_MAX)
        else $error("agc gain outside readback range");
    a_agc_attack: assert property (enable_i && dir_q == AGC_ATTACK && due_w && gain_q > AGC_MIN
        |=> gain_q == $past(gain_q) - 8'sh01)
        else $error("agc attack did not lower gain");
    a_agc_deadband: assert property (enable_i && level_valid_i && lvl_w <= upper_w &&
        lvl_w >= lower_w |=> dir_q == AGC_HOLD)
        else $error("agc moved inside hysteresis band");
endmodule : agc_engine

// File: testbench/tb_pll_softstep_handset_agc_regs.sv
// self-checking bench for the pll, control four and handset gain registers
module tb_pll_softstep_handset_agc_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import codec_regs_pkg::*;
    logic        mclk_i = 0, rst_b_i = 0, psel = 0, penable = 0, pwrite = 0;
    logic        tick = 0, short_i = 0, hsel = 0, pll_en = 1, lv = 0;
    logic [13:0] f_o;
    logic [7:0]  again, lvl = '0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic [6:0]  tgt_s = '0, tgt_c = '0, tgt_b = '0, g_s, g_c, g_b;
    logic [5:0]  j_o;
    logic [1:0]  hb, nb;
    logic        pready, serr, serr_seen, irq, dstep, mute, pv;
    int          fails = 0, check_count = 0;

    always #12.5 mclk_i = ~mclk_i;

    codec_ctrl_regs #(.MS_CYCLES(8)) i_dut (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(serr), .irq_o(irq), .pll_enable_i(pll_en),
        .pll_integer_mult_o(j_o), .pll_fraction_mult_o(f_o), .pll_mult_valid_o(pv),
        .fs_tick_i(tick), .sidetone_target_i(tgt_s), .cell_target_i(tgt_c),
        .buzzer_target_i(tgt_b), .sidetone_gain_o(g_s), .cell_gain_o(g_c),
        .buzzer_gain_o(g_b), .dac_pga_step_off_o(dstep), .headset_bias_level_o(hb),
        .handset_bias_level_o(nb), .short_detect_i(short_i), .handset_sel_i(hsel),
        .adc_level_valid_i(lv), .adc_level_i(lvl), .adc_gain_o(again), .adc_mute_o(mute)
    );

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // request held until pready is sampled high, then released
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge mclk_i);
        penable <= 1'b1;
        do @(posedge mclk_i); while (pready !== 1'b1);
        rdat = prdata;
        serr_seen = serr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        xfer(1'b0, a, 16'h0000);
        chk(nm, rdat, exp);
    endtask : rd

    task automatic tick_once;
        @(posedge mclk_i);
        tick <= 1'b1;
        @(posedge mclk_i);
        tick <= 1'b0;
        // one more edge so the stepped gains are settled when looked at
        @(posedge mclk_i);
    endtask : tick_once

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    initial begin
        repeat (12) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        chk("mute", mute, 1);
        rd(ADDR_HS_GAIN, 32'h0000FF00, "hs rst");
        chk("adc gain", again, 8'h7F);
        rd(ADDR_PLL_INT, 32'h00000004, "j rst");
        rd(ADDR_PLL_FRAC, 32'h00000000, "frac rst");
        rd(ADDR_CTRL4, 32'h00000000, "ctrl4 rst");
        $display("reset test done");
        xfer(1'b1, ADDR_PLL_INT, 16'h0000);
        rd(ADDR_PLL_INT, 32'h00000004, "j zero");
        xfer(1'b1, ADDR_PLL_INT, 16'h00FC);
        rd(ADDR_PLL_INT, 32'h000000FC, "j max");
        chk("j out", j_o, 63);
        chk("pll valid", pv, 1);
        xfer(1'b1, ADDR_PLL_FRAC, 16'h9C40);
        rd(ADDR_PLL_FRAC, 32'h00009C3C, "frac clamp");
        chk("frac out", f_o, 14'h270F);
        pll_en <= 1'b0;
        short_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rd(ADDR_CTRL4, 32'h00000002, "short");
        chk("pll off", pv, 0);
        chk("irq masked", irq, 0);
        xfer(1'b1, ADDR_IRQ_MASK, 16'h0006);
        #1 chk("irq on", irq, 1);
        rd(ADDR_IRQ_STAT, 32'h00000007, "status");
        short_i <= 1'b0;
        #1 chk("irq off", irq, 0);
        rd(8'hF0, 32'h00000000, "unmapped");
        chk("unmapped err", serr_seen, 1);
        $display("pll and irq test done");
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, ADDR_CTRL4, {7'h00, i[1:0], i[0], 6'h00});
            #1 chk("headset bias", hb, (i == 3) ? 2 : i);
            chk("handset bias", nb, i[0] ? 2 : 1);
        end
        xfer(1'b1, ADDR_CTRL4, 16'hFFC0);
        rd(ADDR_CTRL4, 32'h0000FFC0, "ctrl4 all");
        chk("dac step off", dstep, 1);
        xfer(1'b1, ADDR_CTRL4, 16'h0000);
        tgt_s <= 7'h0A;
        tgt_c <= 7'h03;
        tgt_b <= 7'h14;
        tick_once;
        chk("side step", g_s, 1);
        chk("cell step", g_c, 1);
        chk("buzz step", g_b, 6);
        xfer(1'b1, ADDR_CTRL4, 16'h2000);
        tick_once;
        chk("side jump", g_s, 10);
        chk("cell step2", g_c, 2);
        chk("buzz step2", g_b, 12);
        $display("stepping test done");
        hsel <= 1'b1;
        xfer(1'b1, ADDR_HS_GAIN, 16'h7F01);
        rd(ADDR_HS_GAIN, 32'h00000001, "agc readback");
        // loud input: attack steps every 16 cycles down to the -12 dB floor
        lv <= 1'b1;
        lvl <= 8'h00;
        repeat (500) @(posedge mclk_i);
        rd(ADDR_HS_GAIN, 32'h0000E801, "agc floor");
        chk("agc gain", again, 8'hE8);
        // quiet input: decay takes 200 cycles per step, so exactly one step
        lvl <= 8'h80;
        repeat (250) @(posedge mclk_i);
        chk("agc decay", again, 8'hE9);
        // level on target sits inside the hysteresis band
        lvl <= 8'hF5;
        repeat (250) @(posedge mclk_i);
        chk("agc hold", again, 8'hE9);
        hsel <= 1'b0;
        rd(ADDR_HS_GAIN, 32'h00007F01, "no handset");
        xfer(1'b1, ADDR_HS_GAIN, 16'hFF00);
        rd(ADDR_HS_GAIN, 32'h0000FF00, "hs back");
        chk("written mute", mute, 1);
        chk("written gain", again, 8'h7F);
        $display("agc test done");
        test_done;
    end

    // hang guard, well beyond the roughly 1100 cycles the tests need
    initial begin
        repeat (5000) @(posedge mclk_i);
        fails++;
        test_done;
    end
endmodule : tb_pll_softstep_handset_agc_regs
